/* hdl/afepp_cic.sv */
// Sinc-N (CIC) decimator with runtime ratio and saturating output
`timescale 1ns/1ps
module afepp_cic #(
  parameter int ORDER = 3,
  parameter int ACC_W = 24
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic in_valid,
  input wire logic [15:0] din,
  input wire logic [10:0] ratio,
  input wire logic [4:0] shift,
  output logic out_valid,
  output logic [15:0] dout
);
  typedef struct packed {
    logic [ORDER-1:0][ACC_W-1:0] integ;
    logic [ORDER-1:0][ACC_W-1:0] dly;
    logic [10:0] cnt;
    logic vld;
    logic [15:0] dout;
  } afepp_cic_s;

  afepp_cic_s st, next_st;

  // Accumulators must cover 16 bits plus sign growth
  if (ORDER < 1 || ACC_W < 17) begin : g_bad_width
    $error("afepp_cic: ORDER or ACC_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Integrate every input, comb and dump once per ratio
  always_comb begin
    logic [ACC_W-1:0] c;
    logic [ACC_W-1:0] d;
    logic signed [ACC_W-1:0] sh;
    c = '0;
    d = '0;
    sh = '0;
    next_st = st;
    next_st.vld = 1'b0;
    if (clr) begin
      next_st.integ = '0;
      next_st.dly = '0;
      next_st.cnt = '0;
    end else if (in_valid) begin
      next_st.integ[0] = st.integ[0] + {{(ACC_W-16){din[15]}}, din};
      for (int k = 1; k < ORDER; k++) begin
        next_st.integ[k] = st.integ[k] + st.integ[k-1];
      end
      if (st.cnt >= ratio - 11'h1) begin
        next_st.cnt = '0;
        c = st.integ[ORDER-1];
        for (int k = 0; k < ORDER; k++) begin
          d = c - st.dly[k];
          next_st.dly[k] = c;
          c = d;
        end
        sh = $signed(c) >>> shift;
        // Clip rather than wrap when the shift undershoots the gain
        if (&sh[ACC_W-1:15] || ~|sh[ACC_W-1:15]) begin
          next_st.dout = sh[15:0];
        end else begin
          next_st.dout = sh[ACC_W-1] ? 16'h8000 : 16'h7fff;
        end
        next_st.vld = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 11'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_valid = st.vld;
  assign dout = st.dout;
endmodule // afepp_cic

/* hdl/afepp_pkg.sv */
// Register map, field positions, reset values and ratio tables
package afepp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FRONTEND_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FILTER_CONFIG = 8'h04;
  localparam logic [7:0] OFS_PRIMARY_RESULT = 8'h08;
  localparam logic [7:0] OFS_SECONDARY_RESULT = 8'h0c;
  localparam logic [7:0] OFS_TRANSFORM_CONFIG = 8'h10;
  localparam logic [7:0] OFS_TRANSFORM_REAL = 8'h14;
  localparam logic [7:0] OFS_TRANSFORM_IMAG = 8'h18;
  localparam logic [7:0] OFS_STATISTICS_CONFIG = 8'h1c;
  localparam logic [7:0] OFS_MEAN_RESULT = 8'h20;
  localparam logic [7:0] OFS_LOWER_LIMIT = 8'h24;
  localparam logic [7:0] OFS_UPPER_LIMIT = 8'h28;
  localparam logic [7:0] OFS_HYSTERESIS = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  // Field positions
  localparam int FE_CONV_EN_BIT = 8;
  localparam int FE_TRANSFORM_EN_BIT = 15;
  localparam int FE_SINC2_EN_BIT = 16;
  localparam int FC_NOTCH_OFF_BIT = 4;
  localparam int FC_SINC3_OFF_BIT = 6;
  localparam int FC_OSR2_LSB = 8;
  localparam int FC_OSR3_LSB = 12;
  localparam int FC_AVG_LSB = 14;
  localparam int TC_WINDOW_BIT = 0;
  localparam int TC_LEN_LSB = 4;
  localparam int TC_SRC_LSB = 20;
  localparam int SC_EN_BIT = 0;
  localparam int SC_CNT_LSB = 4;
  localparam int ST_OUTLIER_BIT = 0;
  localparam int ST_TDONE_BIT = 1;
  localparam int ST_TBUSY_BIT = 2;
  // Reset values
  localparam logic [31:0] RST_FRONTEND_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_FILTER_CONFIG = 32'h0000_1000;
  localparam logic [31:0] RST_TRANSFORM_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_STATISTICS_CONFIG = 32'h0000_0000;
  localparam logic [15:0] RST_LOWER_LIMIT = 16'h0000;
  localparam logic [15:0] RST_UPPER_LIMIT = 16'hffff;
  localparam logic [15:0] RST_HYSTERESIS = 16'h0000;
  localparam logic [15:0] CODE_MIDSCALE = 16'h8000;
  localparam int GAIN_FRAC = 14;
  localparam int LEN_MAX = 12;
  // Transform input sources
  typedef enum logic [1:0] {
    SRC_RAW = 2'h0, SRC_SINC2 = 2'h1, SRC_SINC3 = 2'h2, SRC_NOTCH = 2'h3
  } afepp_src_e;
  // Sinc3 ratio and output shift, packed {ratio[10:0], shift[4:0]}
  function automatic logic [15:0] osr3_lut(input logic [1:0] f);
    case (f)
      2'h0: osr3_lut = {11'd5, 5'd7};
      2'h2: osr3_lut = {11'd2, 5'd3};
      default: osr3_lut = {11'd4, 5'd6};
    endcase
  endfunction
  // Sinc2 ratio and output shift, same packing
  function automatic logic [15:0] osr2_lut(input logic [3:0] f);
    case (f)
      4'h0: osr2_lut = {11'd22, 5'd9};
      4'h1: osr2_lut = {11'd44, 5'd11};
      4'h2: osr2_lut = {11'd89, 5'd13};
      4'h3: osr2_lut = {11'd178, 5'd15};
      4'h4: osr2_lut = {11'd267, 5'd17};
      4'h5: osr2_lut = {11'd533, 5'd19};
      4'h6: osr2_lut = {11'd640, 5'd19};
      4'h7: osr2_lut = {11'd667, 5'd19};
      4'h8: osr2_lut = {11'd800, 5'd20};
      4'h9: osr2_lut = {11'd889, 5'd20};
      4'ha: osr2_lut = {11'd1067, 5'd21};
      default: osr2_lut = {11'd1333, 5'd21};
    endcase
  endfunction
endpackage

/* hdl/afepp_top.sv */
// Converter post-processing chain with AHB-Lite register slave
// Contract
// - Sinc3 takes raw codes at 800 kHz or 1.6 MHz per strobe.
// - Sinc3 runs only while filter_config bit 6 is zero.
// - Sinc3 ratio chosen by filter_config bits 13:12; ratio 4 recommended.
// - Ratio 4 gives 200 kSPS or 400 kSPS sinc3 output.
// - Sinc3 output is readable in primary_result.
// - Clearing conversion_enable (bit 8) restarts sinc3 state.
// - Sinc2 input is corrected sinc3 output or direct converter codes.
// - Sinc2 enabled by frontend_control bit 16.
// - Sinc2 ratio from filter_config bits 11:8, divide 22 to 1333.
// - Sinc2 output is readable in secondary_filter_result.
// - Clearing second_decimator_enable restarts sinc2 state.
// - Notch runs when bit 4 is zero and sinc2 enabled.
// - Code 0b000011 gives sinc3 ratio 5, sinc2 ratio 178.
// - 0b100111 gives ratios 2/667; 0b101011 gives 2/1333.
// - Gain correction applies automatically to sinc2 and notch results.
// - Transform enabled by bit 15; input raw, sinc2, sinc3 or notch.
// - Source from transform_config bits 21:20; real and imaginary results.
// - Transform sample count set by transform_config bits 7:4.
// - Transform_config bit 0 enables taper window; outside samples zeroed.
// - Sinc3 output averaged over count from filter_config bits 15:14.
// - Mean of sinc3 output over count from statistics_config bits 6:4.
// - Interrupt when result below lower or above upper limit; hysteresis.
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module afepp_top
  import afepp_pkg::*;
#(
  parameter logic [15:0] GAIN_COEF = 16'h4000,
  parameter logic [15:0] OFFSET_COEF = 16'h0000
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [15:0] RAW_CODE,
  input wire logic RAW_STROBE,
  output logic OUTLIER_IRQ
);
  import afepp_pkg::*;

  // Gain above 4.0 would overflow the correction product range
  if (GAIN_COEF > 16'hffff || GAIN_FRAC != 14) begin : g_bad_gain
    $error("afepp_top: unsupported gain coefficient format");
  end

  typedef struct packed {
    logic [31:0] fectl;
    logic [31:0] fcfg;
    logic [31:0] tcfg;
    logic [31:0] scfg;
    logic [15:0] lower;
    logic [15:0] upper;
    logic [15:0] hyst;
    logic [15:0] prim;
    logic [15:0] sec;
    logic [15:0] mean;
    logic [31:0] t_re;
    logic [31:0] t_im;
    logic [19:0] avg_acc;
    logic [3:0] avg_cnt;
    logic [23:0] st_acc;
    logic [7:0] st_cnt;
    logic [15:0] t_cnt;
    logic t_busy;
    logic t_done;
    logic t_en_d;
    logic flag;
    logic arm_lo;
    logic arm_hi;
    logic [15:0] notch_prev;
    logic wr;
    logic [7:0] addr;
    logic [31:0] rdata;
  } afepp_top_s;

  afepp_top_s st, next_st;

  ////////////////////////////////////////////////////////////////////////
  // Stream signals between stages
  logic conv_en;
  logic s2_en;
  logic raw_v;
  logic [15:0] raw_s;
  logic [15:0] osr3;
  logic [15:0] osr2;
  logic c3_v;
  logic [15:0] c3_d;
  logic s3_v;
  logic [15:0] s3_d;
  logic s2i_v;
  logic [15:0] s2i_d;
  logic c2_v;
  logic [15:0] c2_d;
  logic [15:0] notch_d;

  // Enables; the converter core shares CLK, so no synchroniser here
  assign conv_en = st.fectl[FE_CONV_EN_BIT];
  assign s2_en = st.fectl[FE_SINC2_EN_BIT];
  assign raw_v = RAW_STROBE & conv_en;
  assign raw_s = RAW_CODE ^ CODE_MIDSCALE;
  assign osr3 = osr3_lut(st.fcfg[FC_OSR3_LSB +: 2]);
  assign osr2 = osr2_lut(st.fcfg[FC_OSR2_LSB +: 4]);

  // Fixed-point gain and offset correction, saturating to 16 bits
  function automatic logic [15:0] correct(input logic [15:0] x);
    logic signed [33:0] p;
    logic signed [33:0] q;
    p = $signed({{18{x[15]}}, x}) * $signed({18'h0, GAIN_COEF});
    q = (p >>> GAIN_FRAC) + $signed({{18{OFFSET_COEF[15]}}, OFFSET_COEF});
    if (&q[33:15] || ~|q[33:15]) begin
      correct = q[15:0];
    end else begin
      correct = q[33] ? 16'h8000 : 16'h7fff;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sinc3 decimator; held in reset while conversion is off
  afepp_cic #(
    .ORDER(3),
    .ACC_W(24)
  ) u_sinc3 (
    .clk(CLK),
    .resetn(RESETN),
    .clr(!conv_en || st.fcfg[FC_SINC3_OFF_BIT]),
    .in_valid(raw_v),
    .din(raw_s),
    .ratio(osr3[15:5]),
    .shift(osr3[4:0]),
    .out_valid(c3_v),
    .dout(c3_d)
  );

  // Bypass hands raw codes straight on when sinc3 is off
  assign s3_v = st.fcfg[FC_SINC3_OFF_BIT] ? raw_v : c3_v;
  assign s3_d = st.fcfg[FC_SINC3_OFF_BIT] ? raw_s : c3_d;

  // Correction sits ahead of sinc2; notch has unity DC gain, sinc2 gain is ratio squared over 2^shift
  assign s2i_v = s3_v & s2_en;
  assign s2i_d = correct(s3_d);

  afepp_cic #(
    .ORDER(2),
    .ACC_W(40)
  ) u_sinc2 (
    .clk(CLK),
    .resetn(RESETN),
    .clr(!conv_en || !s2_en),
    .in_valid(s2i_v),
    .din(s2i_d),
    .ratio(osr2[15:5]),
    .shift(osr2[4:0]),
    .out_valid(c2_v),
    .dout(c2_d)
  );

  // Two-tap mains notch on the sinc2 rate; zero lands at half that rate
  assign notch_d = 16'(($signed({c2_d[15], c2_d})
    + $signed({st.notch_prev[15], st.notch_prev})) >>> 1);

  ////////////////////////////////////////////////////////////////////////
  // Register read mux; unmapped words read zero
  function automatic logic [31:0] rd_mux(input afepp_top_s s,
                                         input logic [7:0] a);
    case (a)
      OFS_FRONTEND_CONTROL: rd_mux = s.fectl;
      OFS_FILTER_CONFIG: rd_mux = s.fcfg;
      OFS_PRIMARY_RESULT: rd_mux = {16'h0, s.prim};
      OFS_SECONDARY_RESULT: rd_mux = {16'h0, s.sec};
      OFS_TRANSFORM_CONFIG: rd_mux = s.tcfg;
      OFS_TRANSFORM_REAL: rd_mux = s.t_re;
      OFS_TRANSFORM_IMAG: rd_mux = s.t_im;
      OFS_STATISTICS_CONFIG: rd_mux = s.scfg;
      OFS_MEAN_RESULT: rd_mux = {16'h0, s.mean};
      OFS_LOWER_LIMIT: rd_mux = {16'h0, s.lower};
      OFS_UPPER_LIMIT: rd_mux = {16'h0, s.upper};
      OFS_HYSTERESIS: rd_mux = {16'h0, s.hyst};
      OFS_STATUS: rd_mux = {29'h0, s.t_busy, s.t_done, s.flag};
      default: rd_mux = 32'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus first, datapath after so hardware sets win
  always_comb begin
    logic [15:0] pc;
    logic [15:0] tx;
    logic [15:0] tw;
    logic tv;
    logic [15:0] tn;
    logic [2:0] sf;
    logic [3:0] af;
    logic [3:0] lf;
    pc = '0;
    tx = '0;
    tw = '0;
    tv = 1'b0;
    tn = '0;
    sf = st.scfg[SC_CNT_LSB +: 3];
    af = {2'h0, st.fcfg[FC_AVG_LSB +: 2]};
    lf = st.tcfg[TC_LEN_LSB +: 4];
    if (lf > 4'(LEN_MAX)) begin
      lf = 4'(LEN_MAX);
    end
    tn = 16'(16'h4 << lf);
    next_st = st;

    // Data phase of a write takes HWDATA
    if (st.wr) begin
      case (st.addr)
        OFS_FRONTEND_CONTROL: next_st.fectl = HWDATA;
        OFS_FILTER_CONFIG: next_st.fcfg = HWDATA;
        OFS_TRANSFORM_CONFIG: next_st.tcfg = HWDATA;
        OFS_STATISTICS_CONFIG: next_st.scfg = HWDATA;
        OFS_LOWER_LIMIT: next_st.lower = HWDATA[15:0];
        OFS_UPPER_LIMIT: next_st.upper = HWDATA[15:0];
        OFS_HYSTERESIS: next_st.hyst = HWDATA[15:0];
        OFS_STATUS: begin
          if (HWDATA[ST_OUTLIER_BIT]) begin
            next_st.flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Address phase; read data registered for the data phase
    next_st.wr = 1'b0;
    if (HSEL && HREADY && HTRANS[1]) begin
      next_st.wr = HWRITE && HADDR[31:8] == 24'h0;
      next_st.addr = HADDR[31:8] == 24'h0 ? HADDR[7:0] : 8'hff;
      next_st.rdata = rd_mux(st, HADDR[7:0]);
      if (HADDR[31:8] != 24'h0) begin
        next_st.rdata = 32'h0;
      end
    end

    // Averaging of the sinc3 stream into primary_result
    if (!conv_en) begin
      next_st.avg_acc = '0;
      next_st.avg_cnt = '0;
    end else if (s3_v) begin
      if (st.avg_cnt == 4'((4'h1 << af) - 4'h1)) begin
        next_st.prim = 16'(($signed(st.avg_acc)
          + $signed({{4{s3_d[15]}}, s3_d})) >>> af) ^ CODE_MIDSCALE;
        next_st.avg_acc = '0;
        next_st.avg_cnt = '0;
        pc = 16'(($signed(st.avg_acc)
          + $signed({{4{s3_d[15]}}, s3_d})) >>> af) ^ CODE_MIDSCALE;
        // Outlier check with re-arm only past the hysteresis band
        if (pc < st.lower) begin
          if (st.arm_lo) begin
            next_st.flag = 1'b1;
          end
          next_st.arm_lo = 1'b0;
        end else if ({1'b0, pc} >= {1'b0, st.lower} + {1'b0, st.hyst}) begin
          next_st.arm_lo = 1'b1;
        end
        if (pc > st.upper) begin
          if (st.arm_hi) begin
            next_st.flag = 1'b1;
          end
          next_st.arm_hi = 1'b0;
        end else if ({1'b0, pc} + {1'b0, st.hyst} <= {1'b0, st.upper}) begin
          next_st.arm_hi = 1'b1;
        end
      end else begin
        next_st.avg_acc = st.avg_acc + {{4{s3_d[15]}}, s3_d};
        next_st.avg_cnt = st.avg_cnt + 4'h1;
      end
    end

    // Mean statistics over 2^n sinc3 samples
    if (!st.scfg[SC_EN_BIT] || !conv_en) begin
      next_st.st_acc = '0;
      next_st.st_cnt = '0;
    end else if (s3_v) begin
      if (st.st_cnt == 8'((9'h1 << sf) - 9'h1)) begin
        next_st.mean = 16'(($signed(st.st_acc)
          + $signed({{8{s3_d[15]}}, s3_d})) >>> sf) ^ CODE_MIDSCALE;
        next_st.st_acc = '0;
        next_st.st_cnt = '0;
      end else begin
        next_st.st_acc = st.st_acc + {{8{s3_d[15]}}, s3_d};
        next_st.st_cnt = st.st_cnt + 8'h1;
      end
    end

    // Sinc2 or notch result, both already gain corrected
    if (!s2_en) begin
      next_st.notch_prev = '0;
    end else if (c2_v) begin
      next_st.notch_prev = c2_d;
      if (!st.fcfg[FC_NOTCH_OFF_BIT]) begin
        next_st.sec = notch_d ^ CODE_MIDSCALE;
      end else begin
        next_st.sec = c2_d ^ CODE_MIDSCALE;
      end
    end

    // Transform input select
    case (afepp_src_e'(st.tcfg[TC_SRC_LSB +: 2]))
      SRC_RAW: begin
        tv = raw_v;
        tx = raw_s;
      end
      SRC_SINC2: begin
        tv = c2_v;
        tx = c2_d;
      end
      SRC_SINC3: begin
        tv = s3_v;
        tx = s3_d;
      end
      SRC_NOTCH: begin
        tv = c2_v && !st.fcfg[FC_NOTCH_OFF_BIT];
        tx = notch_d;
      end
      default: ;
    endcase

    // Taper: outer quarters of the interval weighted by one half
    tw = tx;
    if (st.tcfg[TC_WINDOW_BIT] && (st.t_cnt < (tn >> 2)
        || st.t_cnt >= tn - (tn >> 2))) begin
      tw = 16'($signed(tx) >>> 1);
    end

    // Quarter-rate bin: samples rotate through +re, -im, -re, +im
    next_st.t_en_d = st.fectl[FE_TRANSFORM_EN_BIT];
    if (!st.fectl[FE_TRANSFORM_EN_BIT]) begin
      next_st.t_busy = 1'b0;
    end else if (!st.t_en_d) begin
      next_st.t_busy = 1'b1;
      next_st.t_done = 1'b0;
      next_st.t_cnt = '0;
      next_st.t_re = '0;
      next_st.t_im = '0;
    end else if (st.t_busy && tv) begin
      case (st.t_cnt[1:0])
        2'h0: next_st.t_re = st.t_re + {{16{tw[15]}}, tw};
        2'h1: next_st.t_im = st.t_im - {{16{tw[15]}}, tw};
        2'h2: next_st.t_re = st.t_re - {{16{tw[15]}}, tw};
        default: next_st.t_im = st.t_im + {{16{tw[15]}}, tw};
      endcase
      next_st.t_cnt = st.t_cnt + 16'h1;
      // Samples past the count never enter: the window is zero there
      if (st.t_cnt == tn - 16'h1) begin
        next_st.t_busy = 1'b0;
        next_st.t_done = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register with documented reset values
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= '0;
      st.fectl <= RST_FRONTEND_CONTROL;
      st.fcfg <= RST_FILTER_CONFIG;
      st.tcfg <= RST_TRANSFORM_CONFIG;
      st.scfg <= RST_STATISTICS_CONFIG;
      st.lower <= RST_LOWER_LIMIT;
      st.upper <= RST_UPPER_LIMIT;
      st.hyst <= RST_HYSTERESIS;
      st.prim <= CODE_MIDSCALE;
      st.sec <= CODE_MIDSCALE;
      st.mean <= CODE_MIDSCALE;
      st.arm_lo <= 1'b1;
      st.arm_hi <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Zero-wait slave, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = st.rdata;
  assign OUTLIER_IRQ = st.flag;
endmodule // afepp_top

/* tb/afepp_chk.sv */
// Port-level assertions for the post-processing chain
`timescale 1ns/1ps
module afepp_chk (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [15:0] RAW_CODE,
  input wire logic RAW_STROBE,
  input wire logic OUTLIER_IRQ
);
  logic take;
  logic st_clr;
  logic ph_wr;
  logic ph_rd;
  logic ph_hi;
  logic [7:0] ph_adr;
  logic [31:0] fe_sh;
  logic [15:0] lo_sh;
  assign take = HSEL && HREADY && HTRANS[1];
  assign st_clr = ph_wr && ph_adr == 8'h30 && HWDATA[0];
  ////////////////////////////////////////////////////////////////////////////
  // Data phase tracking; shadows only cover plain read-write registers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_hi <= 1'b0;
      ph_adr <= 8'h00;
      fe_sh <= 32'h0;
      lo_sh <= 16'h0000;
    end else begin
      ph_wr <= take && HWRITE;
      ph_rd <= take && !HWRITE;
      ph_hi <= HADDR[31:8] != 24'h0;
      ph_adr <= HADDR[7:0];
      if (ph_wr && !ph_hi && ph_adr == 8'h00) fe_sh <= HWDATA;
      if (ph_wr && !ph_hi && ph_adr == 8'h24) lo_sh <= HWDATA[15:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  AST_READY: assert property (HREADYOUT)
    else $error("hreadyout dropped");
  AST_OKAY: assert property (!HRESP)
    else $error("error response seen");
  AST_UNMAPPED: assert property (ph_rd && (ph_hi || ph_adr > 8'h30)
    |-> HRDATA == 32'h0) else $error("unmapped read not zero");
  AST_FE_READ: assert property (ph_rd && !ph_hi && ph_adr == 8'h00
    |-> HRDATA == $past(fe_sh))
    else $error("enable bits read back wrong");
  AST_LO_READ: assert property (ph_rd && !ph_hi && ph_adr == 8'h24
    |-> HRDATA[15:0] == $past(lo_sh))
    else $error("lower limit read back wrong");
  AST_IRQ_STICKY: assert property ($fell(OUTLIER_IRQ) |-> $past(st_clr))
    else $error("outlier flag fell without clear");
  AST_ST_READ: assert property (ph_rd && !ph_hi && ph_adr == 8'h30
    |-> HRDATA[0] == $past(OUTLIER_IRQ)) else $error("status bit0 mismatch");
  AST_HOLD: assert property (!$past(take) |-> $stable(HRDATA))
    else $error("read data changed without request");
  cover property ($rose(OUTLIER_IRQ));
  cover property (st_clr);
  cover property (ph_rd && ph_adr == 8'h08);
endmodule // afepp_chk

/* tb/afepp_conv_model.sv */
// Converter core stand-in: periodic one-cycle code strobes
`timescale 1ns/1ps
module afepp_conv_model #(
  parameter int DIV = 31
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] code_in,
  output logic [15:0] raw_code,
  output logic raw_strobe
);
  int cnt;
  // One strobe each DIV cycles, near 800 kHz; code toggles between strobes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      raw_strobe <= 1'b0;
      raw_code <= 16'h0000;
    end else if (cnt == DIV - 1) begin
      cnt <= 0;
      raw_strobe <= 1'b1;
      raw_code <= code_in;
    end else begin
      cnt <= cnt + 1;
      raw_strobe <= 1'b0;
      raw_code <= ~raw_code; // Stale code never looks valid
    end
  end
endmodule // afepp_conv_model

/* tb/tb_adc_postprocess_filter_chain.sv */
// Self-checking bench for the post-processing chain
`timescale 1ns/1ps
module tb_adc_postprocess_filter_chain;
  import afepp_pkg::*;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, raw_strobe, irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] raw_code, code;
  int failures, total_checks, cycles;
  afepp_top dut (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .RAW_CODE(raw_code), .RAW_STROBE(raw_strobe),
    .OUTLIER_IRQ(irq));
  afepp_conv_model conv (.clk(clk), .resetn(resetn), .code_in(code),
    .raw_code(raw_code), .raw_strobe(raw_strobe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Single AHB transfer; master holds each phase until hready is high
  task automatic bus(input logic wr, input logic [31:0] a,
      input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Results settle after several decimated outputs, so poll with a bound
  task automatic poll(input logic [31:0] a, input logic [31:0] exp);
    for (int i = 0; i < 80; i++) begin
      bus(1'b0, a, 32'h0);
      if (rd === exp) break;
      repeat (40) @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] ad [9];
    logic [31:0] ex [9];
    ad = '{32'(OFS_FRONTEND_CONTROL), 32'(OFS_FILTER_CONFIG),
      32'(OFS_TRANSFORM_CONFIG), 32'(OFS_STATISTICS_CONFIG),
      32'(OFS_UPPER_LIMIT), 32'(OFS_PRIMARY_RESULT),
      32'(OFS_SECONDARY_RESULT), 32'h34, 32'h100};
    ex = '{RST_FRONTEND_CONTROL, RST_FILTER_CONFIG, RST_TRANSFORM_CONFIG,
      RST_STATISTICS_CONFIG, {16'h0, RST_UPPER_LIMIT}, 32'h8000, 32'h8000,
      32'h0, 32'h0};
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, ad[i], 32'h0);
      check("reset value", rd, ex[i]);
    end
    check("irq after reset", {31'h0, irq}, 32'h0);
  endtask
  // Limit register holds data; result register ignores writes
  task automatic t_rw();
    bus(1'b1, 32'(OFS_LOWER_LIMIT), 32'h1234);
    bus(1'b0, 32'(OFS_LOWER_LIMIT), 32'h0);
    check("lower limit", rd, 32'h1234);
    bus(1'b1, 32'(OFS_PRIMARY_RESULT), 32'h5555);
    bus(1'b0, 32'(OFS_PRIMARY_RESULT), 32'h0);
    check("primary read only", rd, 32'h8000);
  endtask
  // Ratio 5 loses gain to 125/128; ratios 4 and 2 are exact
  task automatic t_sinc3();
    logic [1:0] fld [3];
    logic [31:0] ex [3];
    fld = '{2'h0, 2'h1, 2'h2};
    ex = '{32'h8fa0, 32'h9000, 32'h9000};
    code <= 16'h9000;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 32'(OFS_FRONTEND_CONTROL), 32'h0);
      bus(1'b1, 32'(OFS_FILTER_CONFIG), {18'h0, fld[i], 12'h0});
      bus(1'b1, 32'(OFS_FRONTEND_CONTROL), 32'h100);
      poll(32'(OFS_PRIMARY_RESULT), ex[i]);
      check("sinc3 result", rd, ex[i]);
    end
    bus(1'b0, 32'(OFS_SECONDARY_RESULT), 32'h0);
    check("sinc2 idle", rd, 32'h8000);
  endtask
  task automatic t_bypass();
    bus(1'b1, 32'(OFS_FRONTEND_CONTROL), 32'h0);
    bus(1'b1, 32'(OFS_FILTER_CONFIG), 32'h1040);
    code <= 16'h8123;
    bus(1'b1, 32'(OFS_FRONTEND_CONTROL), 32'h100);
    poll(32'(OFS_PRIMARY_RESULT), 32'h8123);
    check("bypass result", rd, 32'h8123);
  endtask
  // Raw codes into sinc2 ratio 22 (484/512) and notch; average 4, mean 4
  task automatic t_sinc2();
    code <= 16'h9000;
    bus(1'b1, 32'(OFS_FRONTEND_CONTROL), 32'h0);
    bus(1'b1, 32'(OFS_FILTER_CONFIG), 32'h9040);
    bus(1'b1, 32'(OFS_STATISTICS_CONFIG), 32'h21);
    bus(1'b1, 32'(OFS_FRONTEND_CONTROL), 32'h10100);
    poll(32'(OFS_SECONDARY_RESULT), 32'h8f20);
    check("notch result", rd, 32'h8f20);
    poll(32'(OFS_MEAN_RESULT), 32'h9000);
    check("mean result", rd, 32'h9000);
    bus(1'b0, 32'(OFS_PRIMARY_RESULT), 32'h0);
    check("average result", rd, 32'h9000);
  endtask
  // Flag set by excursion, cleared by write, not re-raised while still out
  task automatic t_outlier();
    bus(1'b1, 32'(OFS_UPPER_LIMIT), 32'h8fff);
    code <= 16'h9000;
    poll(32'(OFS_STATUS), 32'h1);
    check("status flag", rd, 32'h1);
    check("irq raised", {31'h0, irq}, 32'h1);
    bus(1'b1, 32'(OFS_STATUS), 32'h1);
    repeat (300) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    bus(1'b0, 32'(OFS_STATUS), 32'h0);
    check("status cleared", rd, 32'h0);
  endtask
  // Four raw samples; taper halves the first and the last one
  task automatic t_transform();
    bus(1'b1, 32'(OFS_TRANSFORM_CONFIG), 32'h1);
    bus(1'b1, 32'(OFS_FRONTEND_CONTROL), 32'h18100);
    poll(32'(OFS_STATUS), 32'h2);
    check("transform done", rd, 32'h2);
    bus(1'b0, 32'(OFS_TRANSFORM_REAL), 32'h0);
    check("transform real", rd, 32'hfffff800);
    bus(1'b0, 32'(OFS_TRANSFORM_IMAG), 32'h0);
    check("transform imag", rd, 32'hfffff800);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    code = 16'h8000;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_rw();
    t_sinc3();
    t_bypass();
    t_sinc2();
    t_outlier();
    t_transform();
    final_report();
  end
endmodule // tb_adc_postprocess_filter_chain
bind afepp_top afepp_chk chk (.CLK(CLK), .RESETN(RESETN), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
  .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RAW_CODE(RAW_CODE),
  .RAW_STROBE(RAW_STROBE), .OUTLIER_IRQ(OUTLIER_IRQ));
